/* hdl/dio_consts.svh */
`ifndef DIO_CONSTS_SVH
`define DIO_CONSTS_SVH

// Register byte offsets on the Wishbone slave
`define DIO_REG_DIR        8'h00
`define DIO_REG_CHAN_IDX   8'h04
`define DIO_REG_CHAN_LEVEL 8'h08
`define DIO_REG_RISE       8'h0c
`define DIO_REG_FALL       8'h10
`define DIO_REG_MASK       8'h14
`define DIO_REG_QCLEAR     8'h18
`define DIO_REG_FILL       8'h1c
`define DIO_REG_QLEVEL     8'h20
`define DIO_REG_QSTAMP     8'h24
`define DIO_REG_TIMER      8'h28
`define DIO_REG_OUT        8'h2c

// Field layout and reset values
`define DIO_CHANNELS       32
`define DIO_GROUP_SIZE     8
`define DIO_GROUPS         4
`define DIO_IDX_W          5
`define DIO_DIR_RESET      4'h0
`define DIO_MASK_RESET     32'h0000_0000
`define DIO_OUT_RESET      32'h0000_0000

// Timing
`define DIO_CLK_NS         8
`define DIO_SAMPLE_NS      10
`define DIO_TICK_NS        10
`define DIO_QUEUE_DEPTH    511

`endif

/* hdl/dio_pkg.sv */
package dio_pkg;
    typedef logic [31:0] word_t;

    typedef struct packed {
        word_t level;
        word_t stamp;
    } pair_s;
endpackage

/* hdl/capture_if.sv */
`timescale 1ns/1ps
interface capture_if #(
    parameter int CW = 9
);
    import dio_pkg::*;
    logic          push_valid;
    logic          push_ready;
    pair_s         push_data;
    logic          pop_valid;
    logic          pop_ready;
    pair_s         pop_data;
    logic          clear;
    logic [CW-1:0] count;

    modport queue (
        input  push_valid, push_data, pop_ready, clear,
        output push_ready, pop_valid, pop_data, count
    );
    modport feeder (
        output push_valid, push_data, pop_ready, clear,
        input  push_ready, pop_valid, pop_data, count
    );
endinterface

/* hdl/capture_queue.sv */
`timescale 1ns/1ps
`include "dio_consts.svh"
module capture_queue import dio_pkg::*; #(
    parameter int DEPTH = `DIO_QUEUE_DEPTH,
    parameter int CW    = 9
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic reset_n_i,
    // Queue side
    capture_if.queue  q
);
    localparam logic [CW-1:0] LAST = CW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    pair_s         mem_q [DEPTH];
    logic [CW-1:0] wr_ptr_q, wr_ptr_d;
    logic [CW-1:0] rd_ptr_q, rd_ptr_d;
    logic [CW-1:0] count_q,  count_d;
    logic          do_push, do_pop;

    assign q.push_ready = (count_q != FULL);            // [RL14]
    assign q.pop_valid  = (count_q != '0);
    assign q.pop_data   = mem_q[rd_ptr_q];              // [RL20]
    assign q.count      = count_q;                      // [RL16]

    // A full queue refuses the new pair; stored entries stay intact
    assign do_push = q.push_valid && q.push_ready && !q.clear;   // [RL15]
    assign do_pop  = q.pop_ready && q.pop_valid && !q.clear;     // [RL18]

    always_comb begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d  = count_q;
        if (q.clear) begin
            wr_ptr_d = '0;                              // [RL8]
            rd_ptr_d = '0;
            count_d  = '0;
        end else begin
            if (do_push) begin
                wr_ptr_d = (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_d = (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;   // [RL20]
            end
            case ({do_push, do_pop})
                2'b10:   count_d = count_q + 1'b1;
                2'b01:   count_d = count_q - 1'b1;
                default: count_d = count_q;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    // Storage has no reset: a slot is only read after it was written
    always_ff @(posedge mclk_i) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= q.push_data;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    fill_bound_a: assert property (count_q <= FULL)                          // [RL14]
        else $error("queue count above depth");
    full_drop_a: assert property (                                           // [RL15]
        (count_q == FULL) && !q.pop_ready && !q.clear |=> count_q == FULL
            && wr_ptr_q == $past(wr_ptr_q))
        else $error("full queue accepted a pair");
    clear_empty_a: assert property (q.clear |=> count_q == '0 && !q.pop_valid)  // [RL8]
        else $error("queue not empty after clear");
    order_ptr_a: assert property (do_pop |=> rd_ptr_q != $past(rd_ptr_q))    // [RL20]
        else $error("read pointer did not advance on pop");
endmodule

/* hdl/digital_io_edge_capture.sv */
// Contract
// RL1 - 32 channels; direction per group of 8, bit set means output.
// RL2 - After reset every channel is an input and drives nothing.
// RL3 - Single-channel read of index 0..31 returns its level.
// RL4 - Single-channel read of an output channel is undefined.
// RL5 - Edge query per polarity returns edges seen since previous query.
// RL6 - Edge bits of output channels always read zero.
// RL7 - Each edge query clears the flags it returned.
// RL8 - Queue-clear empties the capture queue.
// RL9 - 32-bit monitor mask picks watched inputs; zero disables capture.
// RL10 - Output channels never produce captures.
// RL11 - Selected inputs are sampled every 10 ns for level changes; sampled on every 8 ns clock here.
// RL12 - Each change pushes an entry holding all 32 levels.
// RL13 - Entry second word is the 100 MHz timer from the same sample.
// RL14 - Queue holds at most 511 pairs.
// RL15 - Pairs arriving at a full queue are dropped.
// RL16 - Fill-count query returns stored pair count.
// RL17 - Fill count spans 0..511, returned as 32 bits.
// RL18 - Queue read removes one pair; software checks fill count first.
// RL19 - Timer is 32-bit, +1 every 10 ns, wraps, readable.
// RL20 - Queue returns entries in first-in first-out order.
// RL21 - Inputs synchronised; one flag set per detected edge.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "dio_consts.svh"
module digital_io_edge_capture import dio_pkg::*; #(
    parameter int DEPTH = `DIO_QUEUE_DEPTH
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Digital channels
    input  wire logic [31:0] digital_channels_i,
    output logic      [31:0] digital_channels_o,
    output logic      [31:0] digital_channels_oe_o
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int SAMPLE_CYC_RAW = `DIO_SAMPLE_NS / `DIO_CLK_NS;
    localparam int SAMPLE_CYC = (SAMPLE_CYC_RAW < 1) ? 1 : SAMPLE_CYC_RAW;
    localparam logic [3:0] CLK_STEP = 4'(`DIO_CLK_NS);
    localparam logic [3:0] TICK_LEN = 4'(`DIO_TICK_NS);
    localparam logic [7:0] DIV_LAST = 8'(SAMPLE_CYC - 1);

    // Expand the 4-bit direction pattern to one bit per channel
    function automatic word_t group_outputs(input logic [3:0] dir);
        word_t m;
        m = '0;
        for (int g = 0; g < `DIO_GROUPS; g++) begin
            m[g*`DIO_GROUP_SIZE +: `DIO_GROUP_SIZE] = {`DIO_GROUP_SIZE{dir[g]}};
        end
        return m;
    endfunction

    // Merge write data into a register under the byte enables
    function automatic word_t apply_sel(input word_t old, input word_t wd,
                                        input logic [3:0] sel);
        word_t r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    capture_if #(.CW(CW)) cq ();

    capture_queue #(
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_queue (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .q         (cq.queue)
    );

    // Register state
    logic [3:0]  dir_q,      dir_d;
    logic [4:0]  chan_idx_q, chan_idx_d;
    word_t       mask_q,     mask_d;
    word_t       out_q,      out_d;
    word_t       rise_q,     rise_d;
    word_t       fall_q,     fall_d;
    word_t       stamp_q,    stamp_d;
    word_t       rdata_q,    rdata_d;
    logic        ack_q,      ack_d;
    // Sampling and timer state
    word_t       sync1_q, sync2_q, prev_q;
    word_t       timer_q,    timer_d;
    logic [3:0]  acc_q,      acc_d;
    logic [7:0]  div_q,      div_d;
    logic        tick, sample_en;

    word_t       out_mask, in_mask;
    word_t       rise_set, fall_set, change;
    logic        access, wr, rd;
    logic [7:0]  adr;
    word_t       rd_val;

    assign out_mask = group_outputs(dir_q);
    assign in_mask  = ~out_mask;
    assign adr      = {wb_adr_i[7:2], 2'b00};
    assign access   = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr       = access && wb_we_i;
    assign rd       = access && !wb_we_i;

    assign digital_channels_oe_o = out_mask;            // [RL1] [RL2]
    assign digital_channels_o    = out_q & out_mask;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // Two-flop synchroniser; only sync2 and later stages feed logic
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= digital_channels_i;              // [RL21]
            sync2_q <= sync1_q;
        end
    end

    // Sample divider; at 8 ns the 10 ns sample period rounds down to every cycle
    always_comb begin
        sample_en = (div_q == DIV_LAST);
        div_d     = sample_en ? '0 : div_q + 8'h01;
    end

    // The 100 MHz timer from a 125 MHz clock: a phase accumulator gives
    // exactly one tick per 10 ns on average, at most one per clock
    // The sum is one bit wider than the accumulator so that 8 + 8 cannot wrap
    always_comb begin
        logic [4:0] sum;
        sum     = {1'b0, acc_q} + {1'b0, CLK_STEP};
        tick    = (sum >= {1'b0, TICK_LEN});
        acc_d   = tick ? 4'(sum - {1'b0, TICK_LEN}) : sum[3:0];
        timer_d = tick ? timer_q + 32'h1 : timer_q;     // [RL19]
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            div_q   <= '0;
            acc_q   <= '0;
            timer_q <= '0;
            prev_q  <= '0;
        end else begin
            div_q   <= div_d;
            acc_q   <= acc_d;
            timer_q <= timer_d;
            if (sample_en) begin
                prev_q <= sync2_q;                      // [RL11]
            end
        end
    end

    // Edge and change detection against the previous sample
    always_comb begin
        rise_set = sample_en ? (sync2_q & ~prev_q & in_mask) : '0;     // [RL5] [RL21]
        fall_set = sample_en ? (~sync2_q & prev_q & in_mask) : '0;
        change   = sample_en ? ((sync2_q ^ prev_q) & mask_q & in_mask) : '0;  // [RL9] [RL10]
    end

    assign cq.push_valid      = |change;                // [RL11]
    assign cq.push_data = '{level: sync2_q, stamp: timer_q};   // [RL12] [RL13]
    assign cq.clear     = wr && (adr == `DIO_REG_QCLEAR);              // [RL8]
    assign cq.pop_ready = rd && (adr == `DIO_REG_QLEVEL);              // [RL18]

    // Read multiplexer
    always_comb begin
        case (adr)
            `DIO_REG_DIR:        rd_val = {28'h0, dir_q};
            `DIO_REG_CHAN_IDX:   rd_val = {27'h0, chan_idx_q};
            `DIO_REG_CHAN_LEVEL: rd_val = {31'h0, sync2_q[chan_idx_q]};  // [RL3] [RL4]
            `DIO_REG_RISE:       rd_val = rise_q & in_mask;            // [RL5] [RL6]
            `DIO_REG_FALL:       rd_val = fall_q & in_mask;            // [RL6]
            `DIO_REG_MASK:       rd_val = mask_q;
            `DIO_REG_FILL:       rd_val = 32'(cq.count);               // [RL16] [RL17]
            `DIO_REG_QLEVEL:     rd_val = cq.pop_valid ? cq.pop_data.level : '0;  // [RL18]
            `DIO_REG_QSTAMP:     rd_val = stamp_q;
            `DIO_REG_TIMER:      rd_val = timer_q;                     // [RL19]
            `DIO_REG_OUT:        rd_val = out_q;
            default:             rd_val = '0;
        endcase
    end

    // Register file next state; hardware set wins over a read clear
    always_comb begin
        dir_d      = dir_q;
        chan_idx_d = chan_idx_q;
        mask_d     = mask_q;
        out_d      = out_q;
        stamp_d    = stamp_q;
        ack_d      = access;
        rdata_d    = rd ? rd_val : rdata_q;
        rise_d     = rise_q;
        fall_d     = fall_q;
        if (rd && adr == `DIO_REG_RISE) begin
            rise_d = '0;                                // [RL7]
        end
        if (rd && adr == `DIO_REG_FALL) begin
            fall_d = '0;                                // [RL7]
        end
        rise_d = (rise_d | rise_set) & in_mask;
        fall_d = (fall_d | fall_set) & in_mask;
        if (cq.pop_ready) begin
            stamp_d = cq.pop_valid ? cq.pop_data.stamp : '0;   // [RL18]
        end
        if (wr) begin
            case (adr)
                `DIO_REG_DIR: begin
                    if (wb_sel_i[0]) begin
                        dir_d = wb_dat_i[3:0];          // [RL1]
                    end
                end
                `DIO_REG_CHAN_IDX: begin
                    if (wb_sel_i[0]) begin
                        chan_idx_d = wb_dat_i[4:0];     // [RL3]
                    end
                end
                `DIO_REG_MASK:   mask_d = apply_sel(mask_q, wb_dat_i, wb_sel_i);  // [RL9]
                `DIO_REG_OUT:    out_d  = apply_sel(out_q, wb_dat_i, wb_sel_i);
                default:         ;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            dir_q      <= `DIO_DIR_RESET;               // [RL2]
            chan_idx_q <= '0;
            mask_q     <= `DIO_MASK_RESET;
            out_q      <= `DIO_OUT_RESET;
            rise_q     <= '0;
            fall_q     <= '0;
            stamp_q    <= '0;
            rdata_q    <= '0;
            ack_q      <= 1'b0;
        end else begin
            dir_q      <= dir_d;
            chan_idx_q <= chan_idx_d;
            mask_q     <= mask_d;
            out_q      <= out_d;
            rise_q     <= rise_d;
            fall_q     <= fall_d;
            stamp_q    <= stamp_d;
            rdata_q    <= rdata_d;
            ack_q      <= ack_d;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    sequence rise_query_s;
        rd && adr == `DIO_REG_RISE;
    endsequence
    sequence answered_s;
        wb_ack_o;
    endsequence

    reset_inputs_a: assert property (!$past(reset_n_i) |-> digital_channels_oe_o == '0)  // [RL2]
        else $error("channel drives right after reset");
    group_dir_a: assert property (                                         // [RL1]
        wr && adr == `DIO_REG_DIR && wb_sel_i[0] |=>
            digital_channels_oe_o == {{8{$past(wb_dat_i[3])}}, {8{$past(wb_dat_i[2])}},
                                      {8{$past(wb_dat_i[1])}}, {8{$past(wb_dat_i[0])}}})
        else $error("group direction mismatch");
    chan_read_a: assert property (                                         // [RL3]
        rd && adr == `DIO_REG_CHAN_LEVEL |=> wb_dat_o == {31'h0, $past(sync2_q[chan_idx_q])})
        else $error("single channel read wrong");
    edge_out_zero_a: assert property (                                     // [RL6]
        rise_query_s ##1 answered_s |-> (wb_dat_o & $past(out_mask)) == '0)
        else $error("edge bit of output channel set");
    edge_clear_a: assert property (                                        // [RL7]
        rise_query_s |=> rise_q == $past(rise_set))
        else $error("edge flags not cleared by query");
    rise_flag_a: assert property (                                         // [RL5]
        rise_set[0] |=> rise_q[0] || $past(!in_mask[0]))
        else $error("rising edge flag lost");
    no_out_capture_a: assert property (                                    // [RL10]
        cq.push_valid |-> |((sync2_q ^ prev_q) & mask_q & in_mask))
        else $error("capture without watched input change");
    mask_off_a: assert property (mask_q == '0 |-> !cq.push_valid)         // [RL9]
        else $error("capture with zero mask");
    push_stamp_a: assert property (                                        // [RL13]
        cq.push_valid |-> cq.push_data.stamp == timer_q && cq.push_data.level == sync2_q)
        else $error("pair words not from one sample");
    timer_rate_a: assert property (!tick |=> tick)                         // [RL19]
        else $error("timer missed a 10 ns tick");
    timer_step_a: assert property (tick |=> timer_q == $past(timer_q) + 32'h1)  // [RL19]
        else $error("timer did not step by one");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
endmodule

/* test/pin_model.sv */
`timescale 1ns/1ps
module pin_model (
    // Levels the outside lines put on undriven pins
    input  wire logic [31:0] level_i,
    // Device side of each pin
    input  wire logic [31:0] dout_i,
    input  wire logic [31:0] oe_i,
    // Resolved pin levels
    output logic      [31:0] pin_o
);
    // A driven pin shows the device value; the outside line yields to it
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            pin_o[i] = oe_i[i] ? dout_i[i] : level_i[i];
        end
    end
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
`include "dio_consts.svh"
module testbench;
    import dio_pkg::*;
    typedef struct packed {
        word_t exp;
        word_t care;
    } note_s;

    logic        mclk_i;
    logic        reset_n_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    word_t       wb_dat_i;
    word_t       wb_dat_o;
    logic        wb_ack_o;
    word_t       pin_level;
    word_t       pin_w;
    word_t       dout_w;
    word_t       oe_w;
    word_t       rnd;
    note_s       notes[$];
    note_s       nt;
    int          n_errors;
    int          total_checks;
    int          cyc_cnt;

    digital_io_edge_capture #(.DEPTH(7)) dut (
        .mclk_i                (mclk_i),
        .reset_n_i             (reset_n_i),
        .wb_cyc_i              (wb_cyc_i),
        .wb_stb_i              (wb_stb_i),
        .wb_we_i               (wb_we_i),
        .wb_adr_i              (wb_adr_i),
        .wb_sel_i              (wb_sel_i),
        .wb_dat_i              (wb_dat_i),
        .wb_dat_o              (wb_dat_o),
        .wb_ack_o              (wb_ack_o),
        .digital_channels_i    (pin_w),
        .digital_channels_o    (dout_w),
        .digital_channels_oe_o (oe_w)
    );

    pin_model lines (
        .level_i (pin_level),
        .dout_i  (dout_w),
        .oe_i    (oe_w),
        .pin_o   (pin_w)
    );

    always #4 mclk_i = ~mclk_i;

    function automatic word_t lfsr(input word_t s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction

    function automatic word_t grp(input logic [3:0] d);
        return {{8{d[3]}}, {8{d[2]}}, {8{d[1]}}, {8{d[0]}}};
    endfunction

    task automatic check(input word_t seen, input word_t exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Classic single cycle; the answer is waited for, never assumed
    task automatic wb(input logic we, input logic [7:0] adr, input word_t dat,
                      output word_t rdat);
        int n;
        n = 0;
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            $display("[ERR] %0t bus answer missing", $time);
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] adr, input word_t exp, input word_t care,
                      output word_t rdat);
        notes.push_back('{exp, care});
        wb(1'b0, adr, 32'h0, rdat);
    endtask

    task automatic wr(input logic [7:0] adr, input word_t dat);
        word_t unused;
        notes.push_back('{32'h0, 32'h0});
        wb(1'b1, adr, dat, unused);
    endtask

    task automatic set_pins(input word_t v, input int gap);
        @(posedge mclk_i);
        pin_level <= v;
        repeat (gap - 1) @(posedge mclk_i);
    endtask

    // Every answer is matched against the oldest note the driver left
    always @(posedge mclk_i) begin
        if (wb_ack_o === 1'b1) begin
            if (notes.size() == 0) begin
                n_errors++;
                $display("[ERR] %0t answer without request", $time);
            end else begin
                nt = notes.pop_front();
                if (nt.care != 32'h0) check(wb_dat_o & nt.care, nt.exp & nt.care);
            end
        end
    end

    always @(posedge mclk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 8000) begin
            n_errors++;
            $display("[ERR] %0t run too long", $time);
            end_sim();
        end
    end

    initial begin
        word_t v;
        word_t p0;
        word_t p1;
        word_t s;
        word_t lv[9];
        mclk_i = 1'b0;
        reset_n_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        pin_level = 32'h0;
        rnd = 32'hc4e7be2d;
        n_errors = 0;
        total_checks = 0;
        cyc_cnt = 0;
        repeat (3) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        check(oe_w, 32'h0);
        rd(`DIO_REG_DIR, 32'h0, 32'hffff_ffff, v);
        rd(`DIO_REG_MASK, 32'h0, 32'hffff_ffff, v);
        rd(`DIO_REG_FILL, 32'h0, 32'hffff_ffff, v);
        rd(8'h3c, 32'h0, 32'hffff_ffff, v);
        check(oe_w, 32'h0);
        $display("reset test done");

        wr(`DIO_REG_OUT, 32'hffff_ffff);
        for (int d = 0; d < 16; d++) begin
            wr(`DIO_REG_DIR, d);
            check(oe_w, grp(d[3:0]));
            check(dout_w, grp(d[3:0]));
            rd(`DIO_REG_DIR, d, 32'h0000_000f, v);
        end
        $display("direction test done");

        wr(`DIO_REG_DIR, 32'h0);
        rnd = lfsr(rnd);
        p0 = rnd;
        set_pins(p0, 5);
        for (int i = 0; i < 32; i++) begin
            wr(`DIO_REG_CHAN_IDX, i);
            rd(`DIO_REG_CHAN_LEVEL, {31'h0, p0[i]}, 32'h1, v);
        end
        $display("channel read test done");

        wr(`DIO_REG_DIR, 32'hc);
        wr(`DIO_REG_OUT, 32'h0);
        rd(`DIO_REG_RISE, 32'h0, 32'h0, v);
        rd(`DIO_REG_FALL, 32'h0, 32'h0, v);
        rnd = lfsr(rnd);
        p1 = rnd;
        wr(`DIO_REG_OUT, 32'hffff_0000);
        set_pins(p1, 6);
        rd(`DIO_REG_RISE, ~p0 & p1 & 32'h0000_ffff, 32'hffff_ffff, v);
        rd(`DIO_REG_FALL, p0 & ~p1 & 32'h0000_ffff, 32'hffff_ffff, v);
        rd(`DIO_REG_RISE, 32'h0, 32'hffff_ffff, v);
        rd(`DIO_REG_FALL, 32'h0, 32'hffff_ffff, v);
        $display("edge flag test done");

        wr(`DIO_REG_MASK, 32'h0);
        set_pins(32'h0, 6);
        wr(`DIO_REG_QCLEAR, 32'h1);
        set_pins(32'h0000_00ff, 6);
        rd(`DIO_REG_FILL, 32'h0, 32'hffff_ffff, v);
        wr(`DIO_REG_MASK, 32'hffff_fffe);
        set_pins(32'h0000_00fe, 6);
        rd(`DIO_REG_FILL, 32'h0, 32'hffff_ffff, v);
        wr(`DIO_REG_OUT, 32'h0001_0000);
        repeat (6) @(posedge mclk_i);
        rd(`DIO_REG_FILL, 32'h0, 32'hffff_ffff, v);
        // Changes exactly 50 clocks apart: the stamps must step by 40
        for (int k = 0; k < 9; k++) begin
            rnd = lfsr(rnd);
            lv[k] = (rnd & 32'h0000_fffc) | (k[0] ? 32'h2 : 32'h0);
            set_pins(lv[k], 50);
        end
        for (int k = 0; k < 7; k++) begin
            rd(`DIO_REG_FILL, 7 - k, 32'hffff_ffff, v);
            rd(`DIO_REG_QLEVEL, lv[k], 32'h0000_ffff, v);
            rd(`DIO_REG_QSTAMP, s + 32'd40, (k == 0) ? 32'h0 : 32'hffff_ffff, s);
        end
        rd(`DIO_REG_FILL, 32'h0, 32'hffff_ffff, v);
        rd(`DIO_REG_QLEVEL, 32'h0, 32'hffff_ffff, v);
        set_pins(32'h0000_0002, 6);
        set_pins(32'h0000_0006, 6);
        set_pins(32'h0000_0004, 6);
        rd(`DIO_REG_FILL, 32'h3, 32'hffff_ffff, v);
        wr(`DIO_REG_QCLEAR, 32'h1);
        rd(`DIO_REG_FILL, 32'h0, 32'hffff_ffff, v);
        $display("capture queue test done");

        rd(`DIO_REG_TIMER, 32'h0, 32'h0, s);
        repeat (22) @(posedge mclk_i);
        rd(`DIO_REG_TIMER, s + 32'd20, 32'hffff_ffff, v);
        $display("timer test done");
        repeat (4) @(posedge mclk_i);
        end_sim();
    end
endmodule
